// [rtl/sar_adc_conversion_sequencer.sv]
// Conversion sequencer: shutdown, acquisition, stretched conversion, readout.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Conversion steps on an internal 4MHz enable, never on the bus clock.
// - Every conversion yields a 16-bit result sent out serially.
// - After power-on reset the block sits in shutdown.
// - Acquisition spans exactly two bus clock cycles before conversion.
// - Sampling switch rests in hold, tracks only in acquisition window.
// - Bus clock is held low while converting, released when done.
// - Result builds in an internal register, shifted out after release.
// - Bus address is 011 then the four strap bits.
// - Acknowledged address alone starts acquisition and conversion.
// - Most significant byte goes out first, then the low byte.
// - Master ack of a result starts another; nack ends and frees bus.
module sar_adc_conversion_sequencer
    import sar_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic scl_in,
    input wire link_ev_t ev_in,
    input wire logic addr_strap_bit0_in,
    input wire logic addr_strap_bit1_in,
    input wire logic addr_strap_bit2_in,
    input wire logic addr_strap_bit3_in,
    input wire logic comp_in,
    output logic scl_out,
    output logic scl_oe_n_out,
    output logic track_out,
    output logic powered_out,
    output logic data_bit_out,
    output logic [6:0] own_addr_out,
    output logic [RESULT_W-1:0] dac_code_out
);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONV_DIV - 1);
    localparam int BIT_W = $clog2(RESULT_W);
    localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(RESULT_W - 1);

    logic rst_meta_q;
    logic rst_n;
    logic [DIV_W-1:0] div_q;
    logic tick_q;
    logic scl_prev_q;
    logic scl_fall;
    logic [1:0] acq_cnt_q;
    logic [BIT_W-1:0] bit_cnt_q;
    logic [RESULT_W-1:0] shreg_q;
    logic eng_busy;
    logic eng_done;
    seq_state_t state_q;
    seq_state_t state_d;

    // Reset release is synchronised so no flop leaves reset on a split edge.
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta_q <= RESET_LOW;
            rst_n <= RESET_LOW;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == DIV_LAST);
            div_q <= (div_q == DIV_LAST) ? '0 : div_q + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            own_addr_out <= '0;
        end else begin
            own_addr_out <= {ADDR_FIXED, addr_strap_bit3_in, addr_strap_bit2_in,
                             addr_strap_bit1_in, addr_strap_bit0_in};
        end
    end

    // Bus clock edge detect; the pin is already synchronous to clk_in.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_prev_q <= 1'b1;
        end else begin
            scl_prev_q <= scl_in;
        end
    end
    assign scl_fall = scl_prev_q && !scl_in;

    // The engine is a separate block so its bit loop stays self-contained.
    // 16-bit result
    successive_approx_engine #(
        .WIDTH(RESULT_W)
    ) u_engine (
        .clk_in(clk_in),
        .rst_n_in(rst_n),
        .tick_in(tick_q),
        .start_in(state_q == ST_HOLD),
        .comp_in(comp_in),
        .code_out(dac_code_out),
        .busy_out(eng_busy),
        .done_out(eng_done)
    );

    // Sequence: a nack anywhere in readout wins over further shifting.
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_SHUTDOWN: begin
                if (ev_in.addr_ack) begin
                    state_d = ST_ACQ;
                end
            end
            ST_ACQ: begin
                if (scl_fall && acq_cnt_q == 2'(ACQ_CYCLES - 1)) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                state_d = ST_CONV;
            end
            ST_CONV: begin
                if (eng_done) begin
                    state_d = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (ev_in.nack) begin
                    state_d = ST_SHUTDOWN;
                end else if (ev_in.shift && bit_cnt_q == BIT_LAST) begin
                    state_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (ev_in.nack) begin
                    state_d = ST_SHUTDOWN;
                end else if (ev_in.ack) begin
                    state_d = ST_ACQ;
                end
            end
            default: begin
                state_d = ST_SHUTDOWN;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SHUTDOWN;
        end else begin
            state_q <= state_d;
        end
    end

    // Falling bus clock edges counted only inside the acquisition window.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            acq_cnt_q <= '0;
        end else if (state_q != ST_ACQ) begin
            acq_cnt_q <= '0;
        end else if (scl_fall) begin
            acq_cnt_q <= acq_cnt_q + 1'b1;
        end
    end

    // Pin and power outputs follow the next state so they move with it.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            scl_out <= 1'b0;
            scl_oe_n_out <= 1'b1;
            track_out <= 1'b0;
            powered_out <= 1'b0;
        end else begin
            scl_out <= 1'b0;
            scl_oe_n_out <= !(state_d == ST_HOLD || state_d == ST_CONV);
            track_out <= (state_d == ST_ACQ);
            powered_out <= (state_d != ST_SHUTDOWN);
        end
    end

    // The shifter is loaded only on a finished conversion, so a byte in
    // flight never sees a half-built code from the engine.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            shreg_q <= '0;
            bit_cnt_q <= '0;
            data_bit_out <= 1'b0;
        end else if (state_q == ST_CONV && eng_done) begin
            shreg_q <= dac_code_out;
            bit_cnt_q <= '0;
            data_bit_out <= dac_code_out[RESULT_W-1];
        end else if (state_q == ST_SHIFT && ev_in.shift && !ev_in.nack) begin
            shreg_q <= {shreg_q[RESULT_W-2:0], 1'b0};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            data_bit_out <= shreg_q[RESULT_W-2];
        end
    end

    // Helper count of clocks since the last conversion enable. It starts at
    // all ones so the first pulse after reset is judged like the others.
    logic [DIV_W:0] gap_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            gap_q <= '1;
        end else begin
            gap_q <= tick_q ? '0 : gap_q + 1'b1;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_acq_done;
        $fell(track_out) ##0 !scl_oe_n_out;
    endsequence

    a_tick_spacing: assert property (
        tick_q |-> gap_q == (DIV_W + 1)'(CONV_DIV - 1))
        else $error("Conversion clock enable has the wrong period.");
    a_reset_shutdown: assert property (
        $rose(rst_n) |-> !powered_out && scl_oe_n_out && !track_out)
        else $error("Block not in shutdown after reset.");
    a_acq_two_cycles: assert property (
        $fell(track_out) |-> $past(acq_cnt_q) == 2'(ACQ_CYCLES - 1))
        else $error("Acquisition window not two bus clock cycles.");
    a_hold_before_conv: assert property (
        s_acq_done |=> !track_out && eng_busy)
        else $error("Switch not in hold when conversion runs.");
    a_stretch_conv: assert property (
        eng_busy |-> !scl_oe_n_out && !scl_out)
        else $error("Bus clock released during conversion.");
    a_release_done: assert property (
        (state_q == ST_CONV && eng_done) |=> scl_oe_n_out)
        else $error("Bus clock not released after conversion.");
    a_msb_first: assert property (
        (state_q == ST_CONV && eng_done) |=>
            data_bit_out == $past(dac_code_out[RESULT_W-1]))
        else $error("First bit out is not the result MSB.");
    a_data_stable: assert property (
        (state_q == ST_SHIFT && !ev_in.shift) |=> $stable(shreg_q))
        else $error("Result changed while being read.");
    a_addr_starts: assert property (
        (state_q == ST_SHUTDOWN && ev_in.addr_ack) |=> track_out && powered_out)
        else $error("Address did not start acquisition.");
    a_ack_restart: assert property (
        (state_q == ST_WAIT && ev_in.ack && !ev_in.nack) |=> track_out)
        else $error("Master ack did not start a new conversion.");
    a_nack_shutdown: assert property (
        ((state_q == ST_SHIFT || state_q == ST_WAIT) && ev_in.nack)
            |=> !powered_out && scl_oe_n_out)
        else $error("Nack did not return the block to shutdown.");
endmodule : sar_adc_conversion_sequencer
`default_nettype wire

// [rtl/sar_seq_pkg.sv]
// Shared constants and types for the conversion sequencer.
package sar_seq_pkg;
    // System clock and the internal conversion clock rate.
    localparam int CLK_HZ = 20_000_000;
    localparam int CONV_HZ = 4_000_000;
    localparam int CONV_DIV = CLK_HZ / CONV_HZ;
    localparam int DIV_W = $clog2(CONV_DIV);
    // Result and framing figures.
    localparam int RESULT_W = 16;
    localparam int ACQ_CYCLES = 2;
    localparam logic [2:0] ADDR_FIXED = 3'h3;
    localparam logic RESET_LOW = 1'b0;

    // Events handed over by the neighbouring bus framing logic.
    typedef struct packed {
        logic addr_ack;
        logic shift;
        logic ack;
        logic nack;
    } link_ev_t;

    typedef enum logic [2:0] {
        ST_SHUTDOWN,
        ST_ACQ,
        ST_HOLD,
        ST_CONV,
        ST_SHIFT,
        ST_WAIT
    } seq_state_t;
endpackage : sar_seq_pkg

// [rtl/successive_approx_engine.sv]
// Successive-approximation engine stepped by the conversion clock enable.
`timescale 1ns/100ps
`default_nettype none
module successive_approx_engine #(
    parameter int WIDTH = 16
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic tick_in,
    input wire logic start_in,
    input wire logic comp_in,
    output logic [WIDTH-1:0] code_out,
    output logic busy_out,
    output logic done_out
);
    localparam int IDX_W = $clog2(WIDTH);
    localparam logic [IDX_W-1:0] TOP_IDX = IDX_W'(WIDTH - 1);

    logic [IDX_W-1:0] idx_q;

    // One bit is decided per conversion clock; the comparator high means
    // the input is at or above the trial code, so the bit is kept.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            code_out <= '0;
            idx_q <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in) begin
                code_out <= {1'b1, {(WIDTH-1){1'b0}}};
                idx_q <= TOP_IDX;
                busy_out <= 1'b1;
            end else if (busy_out && tick_in) begin
                if (!comp_in) begin
                    code_out[idx_q] <= 1'b0;
                end
                if (idx_q == '0) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    code_out[idx_q - 1'b1] <= 1'b1;
                    idx_q <= idx_q - 1'b1;
                end
            end
        end
    end

    int unsigned steps_q;

    // Helper count of decisions taken in the running conversion.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            steps_q <= 0;
        end else if (start_in) begin
            steps_q <= 0;
        end else if (busy_out && tick_in) begin
            steps_q <= steps_q + 1;
        end
    end

    a_result_width: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        done_out |-> steps_q == WIDTH)
        else $error("Conversion did not take one decision per result bit.");
endmodule : successive_approx_engine
`default_nettype wire

// [bench/bus_master_model.sv]
// Two-wire bus master model: drives the bus clock and the framer events.
`timescale 1ns/100ps
`default_nettype none
module bus_master_model
    import sar_seq_pkg::*;
(
    input wire logic clk_in,
    input wire logic scl_oe_n_in,
    input wire logic data_bit_in,
    output logic scl_out,
    output var link_ev_t ev_out
);
    logic scl_drv_q = 1'b1;

    // The line has a pull-up, so it reads low while either side pulls it.
    assign scl_out = scl_drv_q & scl_oe_n_in;

    // No event is pending until a task raises one.
    initial begin
        ev_out = '0;
    end

    // A 12-cycle period (600 ns) keeps the bus clock under the rate cap.
    // rate limit
    task automatic scl_cycle(output logic bit_seen);
        scl_drv_q <= 1'b1;
        repeat (5) @(posedge clk_in);
        // Sample mid-cycle, where the design's data bit has settled.
        @(negedge clk_in);
        bit_seen = data_bit_in;
        @(posedge clk_in);
        scl_drv_q <= 1'b0;
        repeat (6) @(posedge clk_in);
    endtask : scl_cycle

    // One-cycle event pulse; called just after a rising edge.
    task automatic pulse(input link_ev_t ev);
        ev_out <= ev;
        @(posedge clk_in);
        ev_out <= '0;
    endtask : pulse

    // Reads a whole result, one bit per bus clock, advancing after each.
    // read after release
    task automatic read_word(output logic [RESULT_W-1:0] w);
        logic b;
        w = '0;
        for (int i = 0; i < RESULT_W; i++) begin
            scl_cycle(b);
            w = {w[RESULT_W-2:0], b};
            pulse('{shift: 1'b1, default: 1'b0});
        end
    endtask : read_word
endmodule : bus_master_model
`default_nettype wire

// [bench/sar_adc_conversion_sequencer_tb.sv]
// Self-checking bench for the conversion sequencer.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_conversion_sequencer_tb;
    import sar_seq_pkg::*;
    localparam link_ev_t ADDR_EV = '{addr_ack: 1'b1, default: 1'b0};
    localparam link_ev_t ACK_EV = '{ack: 1'b1, default: 1'b0};
    localparam link_ev_t NACK_EV = '{nack: 1'b1, default: 1'b0};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic comp = 1'b0;
    logic [3:0] straps = 4'b0101;
    logic [RESULT_W-1:0] analog = '0;
    wire logic scl;
    link_ev_t ev;
    logic scl_drive;
    logic scl_oe_n;
    logic track;
    logic powered;
    logic data_bit;
    logic [6:0] own_addr;
    logic [RESULT_W-1:0] dac_code;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;

    sar_adc_conversion_sequencer u_dut (
        .clk_in(clk), .nrst_in(nrst), .scl_in(scl), .ev_in(ev),
        .addr_strap_bit0_in(straps[0]), .addr_strap_bit1_in(straps[1]),
        .addr_strap_bit2_in(straps[2]), .addr_strap_bit3_in(straps[3]),
        .comp_in(comp), .scl_out(scl_drive), .scl_oe_n_out(scl_oe_n),
        .track_out(track), .powered_out(powered), .data_bit_out(data_bit),
        .own_addr_out(own_addr), .dac_code_out(dac_code));

    bus_master_model u_bm (
        .clk_in(clk), .scl_oe_n_in(scl_oe_n), .data_bit_in(data_bit),
        .scl_out(scl), .ev_out(ev));

    // Free-running 20 MHz clock.
    initial begin
        forever #25 clk = ~clk;
    end

    // Comparator stand-in; the lag of one clock fits between ticks.
    // external reference: full scale is taken as the reference level.
    always @(posedge clk) begin
        comp <= (analog >= dac_code);
    end

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : complete_run

    // Watchdog: the whole run needs well under this many cycles.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            complete_run();
        end
    end

    task automatic test_reset();
        repeat (4) @(posedge clk);
        @(negedge clk);
        check("powered", powered, 0);
        check("track", track, 0);
        check("stretch_n", scl_oe_n, 1);
        check("own_addr", own_addr, {3'b011, 4'b0101});
        @(posedge clk);
        straps <= 4'b1010;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("own_addr", own_addr, {3'b011, 4'b1010});
        $display("test reset done");
    endtask : test_reset

    // Acquire, convert and read one result; restart skips the address.
    task automatic convert(input logic [15:0] val, input logic restart);
        logic b;
        logic tracked;
        logic [15:0] w;
        int n;
        analog = val;
        @(posedge clk);
        if (!restart) begin
            u_bm.pulse(ADDR_EV);
        end
        @(posedge clk);
        @(negedge clk);
        check("track", track, 1);
        check("powered", powered, 1);
        @(posedge clk);
        u_bm.scl_cycle(b);
        @(negedge clk);
        check("track", track, 1);
        u_bm.scl_cycle(b);
        @(negedge clk);
        check("track", track, 0);
        check("stretch_n", scl_oe_n, 0);
        check("scl_drive", scl_drive, 0);
        n = 0;
        tracked = 1'b0;
        while (scl_oe_n !== 1'b1 && n < 200) begin
            tracked = tracked | track;
            @(posedge clk);
            n++;
        end
        check("conv_len_min", n >= 16 * CONV_DIV - 8, 1);
        check("conv_len_max", n <= 16 * CONV_DIV + 12, 1);
        check("track_conv", tracked, 0);
        check("dac_code", dac_code, val);
        // A new input after completion must leave the held result alone.
        analog = ~val;
        u_bm.read_word(w);
        check("result", w, val);
        $display("test convert %h done", val);
    endtask : convert

    task automatic finish_seq(input logic more);
        u_bm.pulse(more ? ACK_EV : NACK_EV);
        @(posedge clk);
        @(negedge clk);
        check("track_after", track, more);
        check("powered_after", powered, more);
        check("stretch_n", scl_oe_n, 1);
        $display("test end of result done");
    endtask : finish_seq

    task automatic test_refused();
        @(posedge clk);
        u_bm.pulse(ACK_EV);
        repeat (2) @(posedge clk);
        @(negedge clk);
        check("powered_idle", powered, 0);
        check("track_idle", track, 0);
        $display("test refused done");
    endtask : test_refused

    // Main sequence: reset, three conversions, then a stray ack.
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        test_reset();
        convert(16'hA5C3, 1'b0);
        finish_seq(1'b1);
        convert(16'hFFFF, 1'b1);
        finish_seq(1'b1);
        convert(16'h0000, 1'b1);
        finish_seq(1'b0);
        test_refused();
        complete_run();
    end
endmodule : sar_adc_conversion_sequencer_tb
`default_nettype wire
